// ### hw/idu_cfg.svh
`ifndef IDU_CFG_SVH
`define IDU_CFG_SVH

// ****************************************
// widths and field positions
// ****************************************
`define IDU_WORD_W      32
`define IDU_CNT_W       6
`define IDU_CR_LT_BIT   3
`define IDU_CR_GT_BIT   2
`define IDU_CR_EQ_BIT   1
`define IDU_CR_SO_BIT   0
`define IDU_MIN_NEG     32'h8000_0000
`define IDU_MINUS_ONE   32'hFFFF_FFFF
`define IDU_UNDEF_RES   32'h0000_0000

`endif

// ### hw/idu_pkg.sv
package idu_pkg;

  typedef enum logic [2:0] {
    IDU_IDLE = 3'b001,
    IDU_RUN  = 3'b010,
    IDU_DONE = 3'b100
  } idu_state_type;

endpackage

// ### hw/idu_step.sv
`timescale 1ns/1ps
`include "idu_cfg.svh"

// ****************************************
// one restoring step of unsigned division
// ****************************************
module idu_step #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] rem_in,
  input  wire logic [W-1:0] quo_in,
  input  wire logic [W-1:0] dvs,
  output logic      [W-1:0] rem_out,
  output logic      [W-1:0] quo_out
);

  // quotient shift needs at least two bits
  if (W < 2) begin : g_bad_w
    $error("idu_step: word width below two is not supported");
  end

  wire logic [W:0] trial_w;
  wire logic [W:0] diff_w;
  wire logic       fits_w;

  assign trial_w = {rem_in, quo_in[W-1]};
  assign diff_w  = trial_w - {1'b0, dvs};
  assign fits_w  = ~diff_w[W];
  assign rem_out = fits_w ? diff_w[W-1:0] : trial_w[W-1:0];
  assign quo_out = {quo_in[W-2:0], fits_w};

endmodule

// ### hw/idu_top.sv
`timescale 1ns/1ps
`include "idu_cfg.svh"

// Contract
// - signed divide treats both operands as signed and writes the low 32 quotient bits.
// - the signed quotient truncates toward zero, so the remainder follows the dividend sign.
// - only the quotient is written back, never the remainder.
// - signed divide of the most negative value by minus one, or by zero, is undefined.
// - in an undefined case the less-than, greater-than and equal bits are undefined too.
// - in any undefined case the overflow flag is set when overflow recording is enabled.
// - unsigned divide treats both operands as unsigned and writes the 32-bit quotient.
// - the unsigned quotient leaves a remainder below the divisor.
// - unsigned divide by zero is the only undefined unsigned case.
// - dot variants update condition field zero, the others leave it alone.
// - overflow variants may record overflow, the others never touch that flag.
module idu_top
  import idu_pkg::*;
#(
  parameter int WORD_W = `IDU_WORD_W,
  parameter int STEPS  = 1
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              signed_op,
  input  wire logic              cr_update,
  input  wire logic              ov_enable,
  input  wire logic [WORD_W-1:0] dividend_gpr,
  input  wire logic [WORD_W-1:0] divisor_gpr,
  input  wire logic              summary_ovf,
  output logic                   busy,
  output logic                   done,
  output logic      [WORD_W-1:0] quotient,
  output logic                   undefined_case,
  output logic                   cr_write,
  output logic      [3:0]        condition_field_zero,
  output logic                   ovf_write,
  output logic                   overflow_flag
);

  // counter width and step wiring are fixed to one 32-bit step per cycle
  if (WORD_W != 32 || STEPS != 1) begin : g_bad_cfg
    $error("idu_top: only a 32-bit word and one step per cycle are supported");
  end

  // ****************************************
  // operand preparation
  // ****************************************
  wire logic              a_neg_w;
  wire logic              b_neg_w;
  wire logic [WORD_W-1:0] a_mag_w;
  wire logic [WORD_W-1:0] b_mag_w;
  wire logic              div_zero_w;
  wire logic              min_by_m1_w;
  wire logic              undef_w;

  assign a_neg_w     = signed_op & dividend_gpr[WORD_W-1];
  assign b_neg_w     = signed_op & divisor_gpr[WORD_W-1];
  assign a_mag_w     = a_neg_w ? WORD_W'(-dividend_gpr) : dividend_gpr;
  assign b_mag_w     = b_neg_w ? WORD_W'(-divisor_gpr) : divisor_gpr;
  assign div_zero_w  = (divisor_gpr == '0);
  assign min_by_m1_w = signed_op & (dividend_gpr == `IDU_MIN_NEG)
                     & (divisor_gpr == `IDU_MINUS_ONE);
  assign undef_w     = div_zero_w | min_by_m1_w;

  // ****************************************
  // state and iteration registers
  // ****************************************
  idu_state_type           state_r;
  idu_state_type           state_nxt;
  logic [`IDU_CNT_W-1:0]   cnt_r;
  logic [WORD_W-1:0]       rem_r;
  logic [WORD_W-1:0]       quo_r;
  logic [WORD_W-1:0]       dvs_r;
  logic                    neg_res_r;
  logic                    undef_r;
  logic                    cr_upd_r;
  logic                    ov_en_r;
  logic                    so_r;
  wire logic [WORD_W-1:0]  rem_step_w;
  wire logic [WORD_W-1:0]  quo_step_w;
  wire logic               last_w;

  idu_step #(
    .W (WORD_W)
  ) u_step (
    .rem_in  (rem_r),
    .quo_in  (quo_r),
    .dvs     (dvs_r),
    .rem_out (rem_step_w),
    .quo_out (quo_step_w)
  );

  assign last_w = (cnt_r == `IDU_CNT_W'(WORD_W - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IDU_IDLE: if (start) state_nxt = undef_w ? IDU_DONE : IDU_RUN;
      IDU_RUN:  if (last_w) state_nxt = IDU_DONE;
      IDU_DONE: state_nxt = IDU_IDLE;
      default:  state_nxt = IDU_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= IDU_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // capture and iterate
  // ****************************************
  wire logic start_take_w;

  assign start_take_w = (state_r == IDU_IDLE) & start;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r     <= '0;
      rem_r     <= '0;
      quo_r     <= '0;
      dvs_r     <= '0;
      neg_res_r <= 1'b0;
      undef_r   <= 1'b0;
      cr_upd_r  <= 1'b0;
      ov_en_r   <= 1'b0;
      so_r      <= 1'b0;
    end else if (start_take_w) begin
      cnt_r     <= '0;
      rem_r     <= '0;
      quo_r     <= a_mag_w;
      dvs_r     <= b_mag_w;
      neg_res_r <= a_neg_w ^ b_neg_w;
      undef_r   <= undef_w;
      cr_upd_r  <= cr_update;
      ov_en_r   <= ov_enable;
      so_r      <= summary_ovf;
    end else if (state_r == IDU_RUN) begin
      cnt_r <= cnt_r + `IDU_CNT_W'(1);
      rem_r <= rem_step_w;
      quo_r <= quo_step_w;
    end
  end

  // ****************************************
  // result formation
  // ****************************************
  wire logic [WORD_W-1:0] q_signed_w;
  wire logic [WORD_W-1:0] q_final_w;
  wire logic [3:0]        cr_w;
  wire logic              fin_w;

  // magnitude negated when signs differ gives truncation toward zero
  assign q_signed_w = neg_res_r ? WORD_W'(-quo_r) : quo_r;
  assign q_final_w  = undef_r ? `IDU_UNDEF_RES : q_signed_w;
  assign fin_w      = (state_r == IDU_DONE);

  assign cr_w[`IDU_CR_LT_BIT] = ~undef_r & q_final_w[WORD_W-1];
  assign cr_w[`IDU_CR_GT_BIT] = ~undef_r & ~q_final_w[WORD_W-1]
                              & (q_final_w != '0);
  assign cr_w[`IDU_CR_EQ_BIT] = ~undef_r & (q_final_w == '0);
  assign cr_w[`IDU_CR_SO_BIT] = so_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quotient             <= '0;
      condition_field_zero <= '0;
      overflow_flag        <= 1'b0;
      done                 <= 1'b0;
      cr_write             <= 1'b0;
      ovf_write            <= 1'b0;
      undefined_case       <= 1'b0;
    end else begin
      done      <= fin_w;
      cr_write  <= fin_w & cr_upd_r;
      ovf_write <= fin_w & ov_en_r;
      if (fin_w) begin
        quotient             <= q_final_w;
        condition_field_zero <= cr_w;
        overflow_flag        <= undef_r;
        undefined_case       <= undef_r;
      end
    end
  end

  assign busy = (state_r != IDU_IDLE);

endmodule

// ### verification/idu_checker.sv
`timescale 1ns/1ps
// ****************************************
// port checks on the divider
// ****************************************
module idu_checker #(
  parameter int WORD_W = 32
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              start,
  input wire logic              cr_update,
  input wire logic [WORD_W-1:0] divisor_gpr,
  input wire logic              busy,
  input wire logic              done,
  input wire logic [WORD_W-1:0] quotient,
  input wire logic              undefined_case,
  input wire logic              cr_write,
  input wire logic [3:0]        condition_field_zero,
  input wire logic              ovf_write,
  input wire logic              overflow_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire take = start && !busy;
  wire [2:0] sign_bits = {quotient[WORD_W-1], !quotient[WORD_W-1] && |quotient, ~|quotient};
  chk_cr_gate: assert property (cr_write |-> done) else $error("cr write outside done");
  chk_ov_gate: assert property (ovf_write |-> done) else $error("ov write outside done");
  chk_cr_asked: assert property (take && cr_update |-> ##[2:34] cr_write)
    else $error("cr write missing");
  chk_zero_undef: assert property (take && divisor_gpr == 0 |-> ##2 done && undefined_case)
    else $error("divide by zero not flagged");
  chk_undef_ovf: assert property (ovf_write && undefined_case |-> overflow_flag)
    else $error("overflow not set");
  chk_def_noovf: assert property (done && !undefined_case |-> !overflow_flag)
    else $error("overflow on defined result");
  chk_cr_sign: assert property (cr_write && !undefined_case |-> condition_field_zero[3:1] == sign_bits)
    else $error("compare bits wrong");
  chk_q_hold: assert property (!done |=> done || $stable(quotient))
    else $error("quotient moved without done");
  cover property (done && undefined_case);
  cover property (cr_write && ovf_write);
  cover property (done && !undefined_case);
endmodule

// ### verification/idu_regfile_model.sv
`timescale 1ns/1ps
// ****************************************
// issue side: sticky summary overflow
// ****************************************
module idu_regfile_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ovf_write,
  input  wire logic overflow_flag,
  output logic      summary_ovf
);
  logic so_r;
  assign summary_ovf = so_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      so_r <= 1'b0;
    end else if (ovf_write && overflow_flag) begin
      so_r <= 1'b1;
    end
  end
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 0, rst = 1, start = 0, signed_op = 0, cr_update = 0, ov_enable = 0;
  logic [31:0] dividend_gpr = 0, divisor_gpr = 0, quotient;
  logic        busy, done, undefined_case, cr_write, ovf_write, overflow_flag, summary_ovf;
  logic [3:0]  condition_field_zero;
  int          mismatches = 0, checks_done = 0;
  always #10 clk_sys = ~clk_sys;
  idu_top DUT (.clk_sys(clk_sys), .rst(rst), .start(start), .signed_op(signed_op),
    .cr_update(cr_update), .ov_enable(ov_enable), .dividend_gpr(dividend_gpr),
    .divisor_gpr(divisor_gpr), .summary_ovf(summary_ovf), .busy(busy), .done(done),
    .quotient(quotient), .undefined_case(undefined_case), .cr_write(cr_write),
    .condition_field_zero(condition_field_zero), .ovf_write(ovf_write),
    .overflow_flag(overflow_flag));
  idu_regfile_model u_rf (.clk_sys(clk_sys), .rst(rst), .ovf_write(ovf_write),
    .overflow_flag(overflow_flag), .summary_ovf(summary_ovf));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic s, input logic c, input logic o, input logic [31:0] a,
                     input logic [31:0] b);
    logic [31:0] q;
    logic        ud, so;
    int          n;
    ud = (b == 0) || (s && a == 32'h8000_0000 && b == 32'hFFFF_FFFF);
    q = ud ? 0 : (s ? 32'($signed(a) / $signed(b)) : a / b);
    @(posedge clk_sys);
    {start, signed_op, cr_update, ov_enable} <= {1'b1, s, c, o};
    {dividend_gpr, divisor_gpr} <= {a, b};
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    so = summary_ovf;
    chk(busy, 1);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (!done && n < 50);
    chk(done, 1);
    chk(busy, 0);
    chk(undefined_case, ud);
    chk(cr_write, c);
    chk(ovf_write, o);
    if (o) chk(overflow_flag, ud);
    if (!ud) chk(quotient, q);
    if (c && !ud) chk(condition_field_zero, {q[31], !q[31] && |q, ~|q, so});
  endtask
  task automatic t_signed;
    logic [31:0] a[6] = '{32'h0000_0007, 32'hFFFF_FFF9, 32'h0000_0007, 32'hFFFF_FFF9,
                          32'h8000_0000, 32'h8000_0000};
    logic [31:0] b[6] = '{32'h0000_0002, 32'h0000_0002, 32'hFFFF_FFFE, 32'hFFFF_FFFE,
                          32'h0000_0001, 32'h0000_0002};
    for (int i = 0; i < 6; i++) begin
      run(1, i[0], i[1], a[i], b[i]);
    end
  endtask
  task automatic t_unsigned;
    run(0, 1, 1, 32'hFFFF_FFFF, 32'h0000_0010);
    run(0, 0, 1, 32'h8000_0000, 32'hFFFF_FFFF);
    run(0, 1, 0, 32'h0000_0005, 32'h0000_0007);
    chk(summary_ovf, 0);
  endtask
  task automatic t_undef;
    run(0, 0, 0, 32'h1234_5678, 32'h0000_0000);
    chk(summary_ovf, 0);
    run(1, 1, 1, 32'h8000_0000, 32'hFFFF_FFFF);
    run(1, 0, 1, 32'h0000_0009, 32'h0000_0000);
    run(1, 1, 0, 32'hFFFF_FFF0, 32'h0000_0004);
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_unsigned();
    t_signed();
    t_undef();
    end_sim();
  end
endmodule
bind idu_top idu_checker #(.WORD_W(WORD_W)) u_chk (.clk_sys(clk_sys), .rst(rst), .start(start),
  .cr_update(cr_update), .divisor_gpr(divisor_gpr), .busy(busy), .done(done),
  .quotient(quotient), .undefined_case(undefined_case), .cr_write(cr_write),
  .condition_field_zero(condition_field_zero), .ovf_write(ovf_write),
  .overflow_flag(overflow_flag));
